// ==== efs_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
module efs_supervisor import efs_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES // 0.1 s in clocks; shorten in simulation
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  // Drive state
  input wire logic run_active,
  input wire logic dc_injection,
  input wire logic ramp_active,
  input wire logic [15:0] speed_ref_rpm,
  // Feedback and supervision outputs
  output logic [15:0] speed_rpm,
  output logic dir_forward,
  output efs_fault_t faults,
  output logic stop_request,
  output logic [1:0] stop_method,
  output logic speed_integral_en,
  output logic monitor_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Percentage of maximum speed, scaled by 100 to stay integer
  function automatic logic [23:0] pct_of_max(input logic [6:0] pct, input logic [15:0] max_rpm);
    pct_of_max = 24'(pct) * 24'(max_rpm);
  endfunction : pct_of_max

  // Legal monitor ratio: n in 0..1, m in 1..32, (1+n)/m not above 1
  function automatic logic div_ok(input logic [7:0] r);
    logic [7:0] n;
    logic [7:0] m;
    n = r / DIV_N_WEIGHT;
    m = r % DIV_N_WEIGHT;
    div_ok = (n <= 8'h01) && (m != 8'h00) && (m <= DIV_M_MAX) && ((n + 8'h01) <= m);
  endfunction : div_ok

  // Qualification timer: counts 0.1 s ticks, restarts when the cause drops
  function automatic logic [6:0] qual_step(input logic cond, input logic tick, input logic [6:0] cnt);
    if (!cond) begin
      qual_step = 7'h00;
    end else if (tick && cnt != 7'h7f) begin
      qual_step = cnt + 7'h01;
    end else begin
      qual_step = cnt;
    end
  endfunction : qual_step

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  efs_cfg_t cfg_reg, cfg_next;       // Operator settings
  logic [31:0] rdata_reg, rdata_next; // Read data, one cycle after strobe
  logic fault_clr_reg, fault_clr_next; // Fault reset strobe
  efs_fault_t fault_reg, fault_next;
  logic [15:0] speed_reg, speed_next;
  logic [19:0] last_cnt_reg, last_cnt_next;
  logic fwd_reg, fwd_next;
  logic agreed_reg, agreed_next;
  logic int_en_reg, int_en_next;
  logic open_armed;

  // Decode writes; out-of-range field values are dropped and the old value kept
  always_comb begin
    cfg_next = cfg_reg;
    fault_clr_next = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          cfg_next.rotation_phase_select = reg_wdata[0];
          cfg_next.ramp_integral_select = reg_wdata[1];
          cfg_next.flux_vector = reg_wdata[2];
          cfg_next.card = efs_card_t'(reg_wdata[4:3]);
          cfg_next.overspeed_stop_method = reg_wdata[6:5];
          cfg_next.speed_error_stop_method = reg_wdata[8:7];
          cfg_next.open_stop_method = reg_wdata[10:9];
          fault_clr_next = reg_wdata[POS_FAULT_RESET];
        end
        OFS_PPR: begin
          cfg_next.pulses_per_rev = reg_wdata[15:0];
        end
        OFS_TEETH: begin
          if (reg_wdata[9:0] <= TEETH_MAX) cfg_next.motor_side_teeth = reg_wdata[9:0];
          if (reg_wdata[25:16] <= TEETH_MAX) cfg_next.load_side_teeth = reg_wdata[25:16];
        end
        OFS_OVSPD: begin
          if (reg_wdata[6:0] <= OS_LEVEL_MAX) cfg_next.overspeed_level = reg_wdata[6:0];
          if (reg_wdata[20:16] <= OS_DELAY_MAX) cfg_next.overspeed_delay = reg_wdata[20:16];
        end
        OFS_SPDERR: begin
          if (reg_wdata[5:0] <= DEV_LEVEL_MAX) cfg_next.speed_error_level = reg_wdata[5:0];
          if (reg_wdata[22:16] <= DEV_DELAY_MAX) cfg_next.speed_error_delay = reg_wdata[22:16];
        end
        OFS_OPEN: begin
          if (reg_wdata[6:0] <= OPEN_TIME_MAX) cfg_next.open_detect_time = reg_wdata[6:0];
          if (div_ok(reg_wdata[23:16])) cfg_next.monitor_divide_ratio = reg_wdata[23:16];
        end
        OFS_AGREE: begin
          cfg_next.speed_agree_band = reg_wdata[15:0];
          cfg_next.max_speed_rpm = reg_wdata[31:16];
        end
        default: begin
          // Read-only and unmapped addresses ignore writes
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL: rdata_next = {21'h000000, cfg_reg.open_stop_method, cfg_reg.speed_error_stop_method,
                                cfg_reg.overspeed_stop_method, cfg_reg.card, cfg_reg.flux_vector,
                                cfg_reg.ramp_integral_select, cfg_reg.rotation_phase_select};
        OFS_PPR: rdata_next = {16'h0000, cfg_reg.pulses_per_rev};
        OFS_TEETH: rdata_next = {6'h00, cfg_reg.load_side_teeth, 6'h00, cfg_reg.motor_side_teeth};
        OFS_OVSPD: rdata_next = {11'h000, cfg_reg.overspeed_delay, 9'h000, cfg_reg.overspeed_level};
        OFS_SPDERR: rdata_next = {9'h000, cfg_reg.speed_error_delay, 10'h000, cfg_reg.speed_error_level};
        OFS_OPEN: rdata_next = {8'h00, cfg_reg.monitor_divide_ratio, 9'h000, cfg_reg.open_detect_time};
        OFS_AGREE: rdata_next = {cfg_reg.max_speed_rpm, cfg_reg.speed_agree_band};
        OFS_STATUS: rdata_next = {25'h0000000, open_armed, int_en_reg, agreed_reg, fwd_reg, fault_reg};
        OFS_SPEED: rdata_next = {12'h000, last_cnt_reg[19:16], speed_reg} ^
                                {last_cnt_reg[15:0], 16'h0000} ^ {12'h000, last_cnt_reg[19:16], 16'h0000};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Settings take their defaults at reset
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg <= '{rotation_phase_select: 1'b0, ramp_integral_select: 1'b0, flux_vector: 1'b0,
                   card: EFS_CARD_AB_CMP, overspeed_stop_method: 2'h0, speed_error_stop_method: 2'h0,
                   open_stop_method: 2'h0, pulses_per_rev: RST_PPR, motor_side_teeth: RST_TEETH,
                   load_side_teeth: RST_TEETH, overspeed_level: RST_OS_LEVEL, overspeed_delay: RST_OS_DELAY,
                   speed_error_level: RST_DEV_LEVEL, speed_error_delay: RST_DEV_DELAY,
                   open_detect_time: RST_OPEN_TIME, monitor_divide_ratio: RST_DIV_RATIO,
                   speed_agree_band: RST_AGREE_BAND, max_speed_rpm: RST_MAX_RPM};
      rdata_reg <= 32'h0000_0000;
      fault_clr_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
      fault_clr_reg <= fault_clr_next;
    end
  end

  // ---------------------------------------------------------------
  // Encoder front end, speed gate and monitor divider
  // ---------------------------------------------------------------
  logic [2:0] a_sync_reg, a_sync_next; // [0] metastable stage, [1] clean, [2] history
  logic [2:0] b_sync_reg, b_sync_next;
  logic [31:0] gate_reg, gate_next;    // Clocks within the current 0.1 s gate
  logic [19:0] cnt_reg, cnt_next;      // Phase A rising edges this gate
  logic [5:0] acc_reg, acc_next;       // Monitor divider accumulator
  logic mon_reg, mon_next;
  logic a_rise, a_edge, tick, two_phase, gear_on;
  logic [39:0] speed_num;
  logic [25:0] speed_den;
  logic [39:0] speed_quot;
  logic [5:0] div_m, div_n1;

  assign a_rise = a_sync_reg[1] & ~a_sync_reg[2];
  assign a_edge = a_sync_reg[1] ^ a_sync_reg[2];
  assign tick = (gate_reg == 32'(TICK_LEN - 1));
  assign two_phase = (cfg_reg.card == EFS_CARD_AB_CMP) || (cfg_reg.card == EFS_CARD_ABZ_LD);
  // Either zero tooth count, or flux vector mode, runs the encoder unscaled
  assign gear_on = !cfg_reg.flux_vector && (cfg_reg.motor_side_teeth != 10'h000) &&
                   (cfg_reg.load_side_teeth != 10'h000);
  // Only phase A edges are counted, so the rate matches one phase per rev
  assign speed_num = 40'(cnt_reg) * 40'(GATES_PER_MIN) *
                     40'(gear_on ? cfg_reg.load_side_teeth : 10'h001);
  assign speed_den = 26'(cfg_reg.pulses_per_rev) * 26'(gear_on ? cfg_reg.motor_side_teeth : 10'h001);
  assign speed_quot = (speed_den == 26'h0000000) ? 40'h00_0000_0000 : speed_num / 40'(speed_den);
  assign div_n1 = (cfg_reg.monitor_divide_ratio >= DIV_N_WEIGHT) ? 6'h02 : 6'h01;
  assign div_m = 6'(cfg_reg.monitor_divide_ratio % DIV_N_WEIGHT);

  // Edge detection, direction, gate counting and monitor division
  always_comb begin
    a_sync_next = {a_sync_reg[1], a_sync_reg[0], enc_a};
    b_sync_next = {b_sync_reg[1], b_sync_reg[0], enc_b};
    gate_next = tick ? 32'h0000_0000 : gate_reg + 32'h0000_0001;
    cnt_next = tick ? 20'(a_rise) : cnt_reg + 20'(a_rise);
    last_cnt_next = tick ? cnt_reg : last_cnt_reg;
    speed_next = speed_reg;
    if (tick) begin
      speed_next = (speed_quot > 40'h00_0000_ffff) ? 16'hffff : speed_quot[15:0];
    end
    fwd_next = fwd_reg;
    if (!two_phase) begin
      fwd_next = 1'b1; // Single phase cannot tell direction
    end else if (a_rise) begin
      // B still low at A's rise means A leads; select 1 swaps the sense
      fwd_next = ~b_sync_reg[1] ^ cfg_reg.rotation_phase_select;
    end
    acc_next = acc_reg;
    mon_next = mon_reg;
    if (cfg_reg.card != EFS_CARD_AB_CMP) begin
      acc_next = 6'h00;
      mon_next = 1'b0;
    end else if (a_edge) begin
      // Each input half-period adds (1+n); reaching m wraps and toggles the output
      if (acc_reg + div_n1 >= div_m) begin
        acc_next = acc_reg + div_n1 - div_m;
        mon_next = ~mon_reg;
      end else begin
        acc_next = acc_reg + div_n1;
      end
    end
  end

  // Encoder state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      a_sync_reg <= 3'h0;
      b_sync_reg <= 3'h0;
      gate_reg <= 32'h0000_0000;
      cnt_reg <= 20'h00000;
      last_cnt_reg <= 20'h00000;
      speed_reg <= 16'h0000;
      fwd_reg <= 1'b1;
      acc_reg <= 6'h00;
      mon_reg <= 1'b0;
    end else begin
      a_sync_reg <= a_sync_next;
      b_sync_reg <= b_sync_next;
      gate_reg <= gate_next;
      cnt_reg <= cnt_next;
      last_cnt_reg <= last_cnt_next;
      speed_reg <= speed_next;
      fwd_reg <= fwd_next;
      acc_reg <= acc_next;
      mon_reg <= mon_next;
    end
  end

  // ---------------------------------------------------------------
  // Fault supervision
  // ---------------------------------------------------------------
  logic [6:0] os_cnt_reg, os_cnt_next;
  logic [6:0] dev_cnt_reg, dev_cnt_next;
  logic [6:0] open_cnt_reg, open_cnt_next;
  logic stop_reg, stop_next;
  logic [1:0] method_reg, method_next;
  logic [15:0] spd_diff;
  logic os_cond, dev_cond, open_cond;
  efs_fault_t fault_set;

  assign spd_diff = (speed_reg > speed_ref_rpm) ? speed_reg - speed_ref_rpm : speed_ref_rpm - speed_reg;
  assign open_armed = run_active && !dc_injection &&
                      (24'(speed_ref_rpm) * PCT_FULL >= pct_of_max(ARM_PCT[6:0], cfg_reg.max_speed_rpm));
  assign os_cond = 24'(speed_reg) * PCT_FULL > pct_of_max(cfg_reg.overspeed_level, cfg_reg.max_speed_rpm);
  assign dev_cond = agreed_reg &&
                    (24'(spd_diff) * PCT_FULL > pct_of_max(7'(cfg_reg.speed_error_level), cfg_reg.max_speed_rpm));
  // Any phase A edge proves the circuit is closed
  assign open_cond = open_armed && !a_edge;
  assign fault_set.overspeed_fault = os_cond && (os_cnt_reg >= 7'(cfg_reg.overspeed_delay));
  assign fault_set.speed_error_fault = dev_cond && (dev_cnt_reg >= cfg_reg.speed_error_delay);
  assign fault_set.encoder_open_fault = open_cond && (open_cnt_reg >= cfg_reg.open_detect_time);

  // Timers, agreement and latched faults; a new fault wins over a reset
  always_comb begin
    os_cnt_next = qual_step(os_cond, tick, os_cnt_reg);
    dev_cnt_next = qual_step(dev_cond, tick, dev_cnt_reg);
    open_cnt_next = qual_step(open_cond, tick, open_cnt_reg);
    agreed_next = agreed_reg;
    if (!run_active || ramp_active) begin
      agreed_next = 1'b0;
    end else if (spd_diff <= cfg_reg.speed_agree_band) begin
      agreed_next = 1'b1;
    end
    fault_next = (fault_reg & ~{3{fault_clr_reg}}) | fault_set;
    stop_next = |fault_next;
    if (fault_next.overspeed_fault) begin
      method_next = cfg_reg.overspeed_stop_method;
    end else if (fault_next.speed_error_fault) begin
      method_next = cfg_reg.speed_error_stop_method;
    end else begin
      method_next = cfg_reg.open_stop_method;
    end
    // Holding the integral on ramps trades tracking for less overshoot
    int_en_next = !(cfg_reg.flux_vector && ramp_active && !cfg_reg.ramp_integral_select);
  end

  // Supervision registers
  always_ff @(posedge clk) begin
    if (reset) begin
      os_cnt_reg <= 7'h00;
      dev_cnt_reg <= 7'h00;
      open_cnt_reg <= 7'h00;
      agreed_reg <= 1'b0;
      fault_reg <= '0;
      stop_reg <= 1'b0;
      method_reg <= 2'h0;
      int_en_reg <= 1'b1;
    end else begin
      os_cnt_reg <= os_cnt_next;
      dev_cnt_reg <= dev_cnt_next;
      open_cnt_reg <= open_cnt_next;
      agreed_reg <= agreed_next;
      fault_reg <= fault_next;
      stop_reg <= stop_next;
      method_reg <= method_next;
      int_en_reg <= int_en_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign speed_rpm = speed_reg;
  assign dir_forward = fwd_reg;
  assign faults = fault_reg;
  assign stop_request = stop_reg;
  assign stop_method = method_reg;
  assign speed_integral_en = int_en_reg;
  assign monitor_out = mon_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_os_held;
    os_cond && (os_cnt_reg >= 7'(cfg_reg.overspeed_delay));
  endsequence
  sequence s_os_latched;
    fault_reg.overspeed_fault && stop_reg && (method_reg == cfg_reg.overspeed_stop_method);
  endsequence

  chk_teeth_range: assert property (cfg_reg.motor_side_teeth <= TEETH_MAX && cfg_reg.load_side_teeth <= TEETH_MAX)
    else $error("tooth count out of range");
  chk_gear_bypass: assert property ((cfg_reg.flux_vector || cfg_reg.motor_side_teeth == 10'h000) |->
                                    speed_den == 26'(cfg_reg.pulses_per_rev))
    else $error("gear scaling not bypassed");
  chk_dir_decode: assert property ((a_rise && two_phase && !b_sync_reg[1]) |=>
                                   dir_forward == !$past(cfg_reg.rotation_phase_select))
    else $error("direction decode wrong");
  chk_open_arm: assert property ($rose(faults.encoder_open_fault) |-> $past(open_armed))
    else $error("open fault while not armed");
  chk_os_qualify: assert property (s_os_held and !fault_reg.speed_error_fault |=> s_os_latched)
    else $error("overspeed not latched with stop");
  chk_dev_agree: assert property ($rose(faults.speed_error_fault) |-> $past(agreed_reg))
    else $error("deviation fault without agreement");
  chk_fault_latch: assert property ((faults.overspeed_fault && !fault_clr_reg) |=> faults.overspeed_fault)
    else $error("fault dropped without reset");
  chk_timer_restart: assert property (!dev_cond |=> dev_cnt_reg == 7'h00)
    else $error("timer not restarted");
  chk_div_range: assert property (div_ok(cfg_reg.monitor_divide_ratio))
    else $error("illegal monitor ratio");
  chk_monitor_card: assert property ((cfg_reg.card != EFS_CARD_AB_CMP) |=> !monitor_out)
    else $error("monitor active with wrong card");
  chk_integral_hold: assert property ((cfg_reg.flux_vector && ramp_active && !cfg_reg.ramp_integral_select) |=>
                                      !speed_integral_en)
    else $error("integral ran during ramp");

endmodule : efs_supervisor
`default_nettype wire

// ==== efs_pkg.sv ====
`default_nettype none
package efs_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;            // 250 MHz core clock
  localparam int TICK_PERIOD_NS = 100_000_000; // 0.1 s timer and speed gate
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int GATES_PER_MIN = 600;          // 0.1 s gates in one minute

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PPR = 8'h04;
  localparam logic [7:0] OFS_TEETH = 8'h08;
  localparam logic [7:0] OFS_OVSPD = 8'h0c;
  localparam logic [7:0] OFS_SPDERR = 8'h10;
  localparam logic [7:0] OFS_OPEN = 8'h14;
  localparam logic [7:0] OFS_AGREE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_SPEED = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and limits
  // ---------------------------------------------------------------
  localparam int POS_FAULT_RESET = 31;         // CTRL write-only strobe
  localparam int POS_HI_FIELD = 16;            // upper field of paired registers
  localparam int POS_DIV_RATIO = 16;           // in OPEN register
  localparam logic [9:0] TEETH_MAX = 10'h3e8;  // 1000
  localparam logic [6:0] OS_LEVEL_MAX = 7'h78; // 120 %
  localparam logic [4:0] OS_DELAY_MAX = 5'h14; // 2.0 s in 0.1 s
  localparam logic [5:0] DEV_LEVEL_MAX = 6'h32; // 50 %
  localparam logic [6:0] DEV_DELAY_MAX = 7'h64; // 10.0 s
  localparam logic [6:0] OPEN_TIME_MAX = 7'h64; // 10.0 s
  localparam logic [7:0] DIV_M_MAX = 8'h20;    // 32
  localparam logic [7:0] DIV_N_WEIGHT = 8'h64; // hundreds digit weight
  localparam logic [23:0] PCT_FULL = 24'h000064; // 100 %
  localparam logic [23:0] ARM_PCT = 24'h000001;  // 1 % arming threshold

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_PPR = 16'h0400;
  localparam logic [9:0] RST_TEETH = 10'h000;
  localparam logic [6:0] RST_OS_LEVEL = 7'h73;   // 115 %
  localparam logic [4:0] RST_OS_DELAY = 5'h00;
  localparam logic [5:0] RST_DEV_LEVEL = 6'h0a;  // 10 %
  localparam logic [6:0] RST_DEV_DELAY = 7'h05;  // 0.5 s
  localparam logic [6:0] RST_OPEN_TIME = 7'h14;  // 2.0 s
  localparam logic [7:0] RST_DIV_RATIO = 8'h01;
  localparam logic [15:0] RST_AGREE_BAND = 16'h0020;
  localparam logic [15:0] RST_MAX_RPM = 16'h0708;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EFS_CARD_A_OC = 2'h0,   // single phase, open collector
    EFS_CARD_AB_CMP = 2'h1, // two phase, complementary outputs
    EFS_CARD_A_LD = 2'h2,   // single phase, line driver
    EFS_CARD_ABZ_LD = 2'h3  // three phase, line driver
  } efs_card_t;

  typedef struct packed {
    logic rotation_phase_select;
    logic ramp_integral_select;
    logic flux_vector;
    efs_card_t card;
    logic [1:0] overspeed_stop_method;
    logic [1:0] speed_error_stop_method;
    logic [1:0] open_stop_method;
    logic [15:0] pulses_per_rev;
    logic [9:0] motor_side_teeth;
    logic [9:0] load_side_teeth;
    logic [6:0] overspeed_level;
    logic [4:0] overspeed_delay;
    logic [5:0] speed_error_level;
    logic [6:0] speed_error_delay;
    logic [6:0] open_detect_time;
    logic [7:0] monitor_divide_ratio;
    logic [15:0] speed_agree_band;
    logic [15:0] max_speed_rpm;
  } efs_cfg_t;

  typedef struct packed {
    logic encoder_open_fault;
    logic overspeed_fault;
    logic speed_error_fault;
  } efs_fault_t;

endpackage : efs_pkg
`default_nettype wire

// ==== efs_encoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Quadrature shaft encoder: one step a clock, pins hold while stopped
module efs_encoder_model (
  // Clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic rev,
  // Phase pins
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph_reg = 2'h0; // Gray step; four steps make one A pulse
  always @(posedge clk) if (run) ph_reg <= rev ? ph_reg - 2'h1 : ph_reg + 2'h1;
  assign enc_a = ph_reg[1] ^ ph_reg[0];
  assign enc_b = ph_reg[1];
endmodule : efs_encoder_model
`default_nettype wire

// ==== tb_encoder_feedback_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_encoder_feedback_supervisor import efs_pkg::*;;
  logic clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, run_active = 1'h0;
  logic dc_injection = 1'h0, ramp_active = 1'h0, enc_run = 1'h0, enc_rev = 1'h0;
  logic enc_a, enc_b, dir_forward, stop_request, speed_integral_en, monitor_out;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [15:0] speed_ref_rpm = 16'h0, speed_rpm;
  logic [1:0] stop_method;
  efs_fault_t faults;
  int failures = 0, n_tests = 0, k, t;
  // Register rows: address, data written, data read back
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} efs_row_t;
  efs_row_t rows [9] = '{
    '{8'h08, 32'h03e8_03e8, 32'h03e8_03e8},
    '{8'h08, 32'h03e9_0001, 32'h03e8_0001},
    '{8'h0c, 32'h0014_0078, 32'h0014_0078},
    '{8'h0c, 32'h0015_0079, 32'h0014_0078},
    '{8'h10, 32'h0064_0032, 32'h0064_0032},
    '{8'h10, 32'h0065_0033, 32'h0064_0032},
    '{8'h14, 32'h0020_0064, 32'h0020_0064},
    '{8'h14, 32'h0021_0065, 32'h0020_0064},
    '{8'h24, 32'hffff_ffff, 32'h0}};
  efs_encoder_model i_efs_encoder_model (.clk, .run(enc_run), .rev(enc_rev), .enc_a, .enc_b);
  // Short gate so a speed sample takes 40 clocks
  efs_supervisor #(.TICK_LEN(40)) i_efs_supervisor (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .enc_a, .enc_b, .run_active, .dc_injection, .ramp_active, .speed_ref_rpm, .speed_rpm,
    .dir_forward, .faults, .stop_request, .stop_method, .speed_integral_en, .monitor_out);
  initial forever #2 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk("reg", reg_rdata, e);
  endtask : rd
  // Counts monitor toggles over n clocks
  task automatic mon(input int n);
    logic p;
    t = 0;
    p = monitor_out;
    repeat (n) begin
      @(posedge clk);
      #1 t += int'(monitor_out !== p);
      p = monitor_out;
    end
  endtask : mon
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    cyc(3);
    reset <= 1'h0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    // Mid-run reset must restore the TEETH, OVSPD, SPDERR and OPEN defaults
    reset <= 1'h1;
    cyc(3);
    reset <= 1'h0;
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0000_0073);
    rd(8'h10, 32'h0005_000a);
    rd(8'h14, 32'h0001_0014);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h48);
    enc_run <= 1'h1;
    cyc(130);
    chk("spd", 32'(speed_rpm), 32'h1770);
    chk("dir", 32'(dir_forward), 32'h1);
    chk("os", {26'h0, faults, stop_request, stop_method}, 32'h16);
    wr(8'h08, 32'h0002_0000);
    cyc(130);
    chk("spd", 32'(speed_rpm), 32'h1770);
    wr(8'h08, 32'h0002_0001);
    cyc(130);
    chk("spd", 32'(speed_rpm), 32'h2ee0);
    ramp_active <= 1'h1;
    wr(8'h00, 32'h4c);
    cyc(130);
    chk("spd", 32'(speed_rpm), 32'h1770);
    chk("int", 32'(speed_integral_en), 32'h0);
    wr(8'h00, 32'h4e);
    cyc(3);
    chk("int", 32'(speed_integral_en), 32'h1);
    wr(8'h00, 32'h4f);
    cyc(10);
    chk("dir", 32'(dir_forward), 32'h0);
    enc_rev <= 1'h1;
    cyc(10);
    chk("dir", 32'(dir_forward), 32'h1);
    wr(8'h14, 32'h0002_0002);
    mon(80);
    chk("mon", 32'(t >= 19 && t <= 21), 32'h1);
    wr(8'h00, 32'h47);
    cyc(2);
    mon(80);
    chk("mon", 32'(t) | 32'(monitor_out), 32'h0);
    enc_run <= 1'h0;
    cyc(130);
    chk("os", 32'(faults), 32'h2);
    wr(8'h00, 32'h8000_0047);
    cyc(3);
    chk("clr", {30'h0, faults[1], stop_request}, 32'h0);
    run_active <= 1'h1;
    speed_ref_rpm <= 16'h0708;
    dc_injection <= 1'h1;
    cyc(200);
    chk("open", 32'(faults), 32'h0);
    dc_injection <= 1'h0;
    cyc(30);
    chk("open", 32'(faults), 32'h0);
    for (k = 0; k < 100 && faults.encoder_open_fault !== 1'h1; k++) @(posedge clk);
    chk("open", 32'(faults.encoder_open_fault), 32'h1);
    tally_and_finish();
  end
endmodule : tb_encoder_feedback_supervisor
`default_nettype wire
